// [common/pecg_pkg.sv]
/*
  pecg_pkg: register map, field layout, reset values and shared helpers of the
  position error clear and electronic gear block.
  Assumes a 16-bit register port with word addresses.
*/
package pecg_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int RATIO_W = 32;
  localparam int ERR_W = 32;

  // register word addresses
  localparam logic [ADDR_W-1:0] A_NUM_SHORT = 4'h0;
  localparam logic [ADDR_W-1:0] A_DEN_SHORT = 4'h1;
  localparam logic [ADDR_W-1:0] A_NUM_HIGH = 4'h2;
  localparam logic [ADDR_W-1:0] A_NUM_LOW = 4'h3;
  localparam logic [ADDR_W-1:0] A_DEN_HIGH = 4'h4;
  localparam logic [ADDR_W-1:0] A_DEN_LOW = 4'h5;
  localparam logic [ADDR_W-1:0] A_CONTROL = 4'h6;
  localparam logic [ADDR_W-1:0] A_RESTART = 4'h7;
  localparam logic [ADDR_W-1:0] A_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] A_ERR_LOW = 4'h9;
  localparam logic [ADDR_W-1:0] A_ERR_HIGH = 4'hA;

  // reset values
  localparam logic [DATA_W-1:0] RST_SHORT = 16'h0001;
  localparam logic [DATA_W-1:0] RST_HIGH = 16'h0000;
  localparam logic [DATA_W-1:0] RST_LOW = 16'h0001;
  localparam logic [RATIO_W-1:0] RST_RATIO = 32'h0000_0001;

  // legal ranges of the gear parts
  localparam logic [DATA_W-1:0] PART_MIN = 16'h0001;
  localparam logic [DATA_W-1:0] PART_MAX = 16'h270F;
  localparam logic [RATIO_W-1:0] HIGH_SCALE = 32'h0000_2710;

  // control register fields
  localparam int CTL_WIDE_BIT = 0;
  localparam int CTL_MODE_LSB = 1;
  localparam int CTL_MODE_W = 2;
  localparam logic [DATA_W-1:0] RST_CONTROL = 16'h0000;

  // status register fields
  localparam int ST_LOOP_BIT = 0;
  localparam int ST_CLEAR_BIT = 1;
  localparam int ST_WIDE_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_CFGERR_BIT = 4;

  // automatic clear modes
  localparam logic [CTL_MODE_W-1:0] MODE_SOFF = 2'h0;
  localparam logic [CTL_MODE_W-1:0] MODE_NEVER = 2'h1;
  localparam logic [CTL_MODE_W-1:0] MODE_SOFF_OT = 2'h2;

  function automatic logic [RATIO_W-1:0] compose(input logic [DATA_W-1:0] hi,
                                                 input logic [DATA_W-1:0] lo);
    logic [RATIO_W-1:0] prod;
    prod = RATIO_W'(hi) * HIGH_SCALE;
    return prod + RATIO_W'(lo);
  endfunction

endpackage

// [hdl/pecg_gear.sv]
/*
  pecg_gear: scales single reference steps by num/den with the remainder kept.
  Assumes num and den are nonzero and stable except at a flush.
*/
`timescale 1ns/1ps
module pecg_gear #(
  parameter int NUM_W = 32
) (
  // clock and reset
  input logic core_clk_i,
  input logic reset_i,
  // control
  input logic flush_i,
  input logic [NUM_W-1:0] num_i,
  input logic [NUM_W-1:0] den_i,
  // reference steps
  input logic step_i,
  input logic step_dir_i,
  // scaled counts
  output logic cnt_o,
  output logic cnt_dir_o,
  output logic busy_o
);
  logic signed [NUM_W+1:0] rem_q, rem_d;
  logic cnt_q, cnt_dir_q;
  wire signed [NUM_W+1:0] num_s = {2'h0, num_i};
  wire signed [NUM_W+1:0] den_s = {2'h0, den_i};
  wire pos_ready = rem_q >= den_s;
  wire neg_ready = rem_q <= -den_s;
  wire signed [NUM_W+1:0] step_term = !step_i ? '0 : (step_dir_i ? num_s : -num_s);
  // one count drained per cycle; fraction stays in rem_q for later steps
  wire signed [NUM_W+1:0] drain_term = pos_ready ? den_s : (neg_ready ? -den_s : '0);

  assign rem_d = flush_i ? '0 : rem_q + step_term - drain_term;
  assign cnt_o = cnt_q;
  assign cnt_dir_o = cnt_dir_q;
  assign busy_o = pos_ready | neg_ready;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rem_q <= '0;
      cnt_q <= 1'b0;
      cnt_dir_q <= 1'b0;
    end else begin
      rem_q <= rem_d;
      cnt_q <= (pos_ready | neg_ready) & ~flush_i;
      cnt_dir_q <= pos_ready;
    end
  end
endmodule

// [hdl/pecg_errcnt.sv]
/*
  pecg_errcnt: signed position error counter, reference up, feedback down.
  Assumes reference and feedback counts are single-cycle strobes.
*/
`timescale 1ns/1ps
module pecg_errcnt #(
  parameter int W = 32
) (
  // clock and reset
  input logic core_clk_i,
  input logic reset_i,
  // clear
  input logic clear_i,
  // count strobes
  input logic ref_i,
  input logic ref_dir_i,
  input logic fb_i,
  input logic fb_dir_i,
  // error value
  output logic [W-1:0] err_o
);
  logic signed [W-1:0] err_q, err_d;

  function automatic logic signed [2:0] step_val(input logic en, input logic up);
    return !en ? 3'sh0 : (up ? 3'sh1 : -3'sh1);
  endfunction

  wire signed [2:0] delta = step_val(ref_i, ref_dir_i) + step_val(fb_i, !fb_dir_i);

  // clear holds the counter at zero for as long as it is asserted
  assign err_d = clear_i ? '0 : err_q + {{(W-3){delta[2]}}, delta};
  assign err_o = err_q;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      err_q <= '0;
    end else begin
      err_q <= err_d;
    end
  end
endmodule

// [hdl/pecg_top.sv]
/*
  pecg_top: position error clear and electronic gear front end.
  Assumes decoded reference steps and encoder feedback arrive as one-cycle
  strobes synchronous to core_clk_i, and a register port with read data one
  cycle after the read strobe.
*/
// The placing of the registers and strobed register access are this design's own decisions.
//
// Behaviour
// - low clear input forces the position error counter to zero.
// - low clear input disables the position loop.
// - clear mode: at servo-off only, never, or servo-off/overtravel outside zero clamp.
// - without an automatic clear, error pulses survive servo-off.
// - every reference step is scaled by the active gear ratio; the gear flush at a clear or a restart drops a step arriving in that cycle.
// - width select picks the 16-bit pair or composed 32-bit ratio.
// - 16-bit parts take 1 to 65535, default 1, apply at restart.
// - 32-bit ratio part equals high times 10000 plus low.
// - high parts take 0 to 9999, low parts 1 to 9999; high defaults 0, low 1.
`timescale 1ns/1ps
module pecg_top #(
  parameter int RATIO_W = pecg_pkg::RATIO_W,
  parameter int ERR_W = pecg_pkg::ERR_W
) (
  // clock and reset
  input logic core_clk_i,
  input logic reset_i,
  // register port
  input logic [pecg_pkg::ADDR_W-1:0] reg_addr_i,
  input logic [pecg_pkg::DATA_W-1:0] reg_wdata_i,
  input logic reg_write_i,
  input logic reg_read_i,
  output logic [pecg_pkg::DATA_W-1:0] reg_rdata_o,
  // reference from host
  input logic step_pulse_input_i,
  input logic step_dir_i,
  input logic error_clear_in_n_i,
  // drive state
  input logic servo_on_i,
  input logic overtravel_i,
  input logic zero_clamp_i,
  // encoder feedback
  input logic feedback_pulse_i,
  input logic feedback_dir_i,
  // position loop side
  output logic [ERR_W-1:0] position_error_o,
  output logic loop_enable_o,
  output logic error_clearing_o,
  output logic scaled_count_o,
  output logic scaled_dir_o
);
  localparam int DW = pecg_pkg::DATA_W;
  localparam int MW = pecg_pkg::CTL_MODE_W;

  // address match, shared by every write decode line
  function automatic logic reg_hit(input logic [pecg_pkg::ADDR_W-1:0] a,
                                   input logic [pecg_pkg::ADDR_W-1:0] target);
    return a == target;
  endfunction

  // one range test serves every gear part, so the limits live in one place
  function automatic logic in_range(input logic [DW-1:0] v,
                                    input logic [DW-1:0] lo,
                                    input logic [DW-1:0] hi);
    return v >= lo && v <= hi;
  endfunction

  // parameter shadows, written by software
  logic [DW-1:0] num_short_q, den_short_q;
  logic [DW-1:0] num_high_q, num_low_q, den_high_q, den_low_q;
  logic [DW-1:0] control_q;
  // ratio in force, loaded only at restart
  logic [RATIO_W-1:0] act_num_q, act_den_q;
  logic act_wide_q;
  logic cfg_err_q;
  logic [DW-1:0] rdata_q;

  // write decode
  wire wr_num_short = reg_write_i && reg_hit(reg_addr_i, pecg_pkg::A_NUM_SHORT);
  wire wr_den_short = reg_write_i && reg_hit(reg_addr_i, pecg_pkg::A_DEN_SHORT);
  wire wr_num_high = reg_write_i && reg_hit(reg_addr_i, pecg_pkg::A_NUM_HIGH);
  wire wr_num_low = reg_write_i && reg_hit(reg_addr_i, pecg_pkg::A_NUM_LOW);
  wire wr_den_high = reg_write_i && reg_hit(reg_addr_i, pecg_pkg::A_DEN_HIGH);
  wire wr_den_low = reg_write_i && reg_hit(reg_addr_i, pecg_pkg::A_DEN_LOW);
  wire wr_control = reg_write_i && reg_hit(reg_addr_i, pecg_pkg::A_CONTROL);
  // restart is a write strobe only; its data word is ignored
  wire restart = reg_write_i && reg_hit(reg_addr_i, pecg_pkg::A_RESTART);

  // out-of-range values are dropped so a zero denominator never reaches the gear
  wire short_ok = in_range(reg_wdata_i, pecg_pkg::PART_MIN, '1);
  // high parts keep zero legal, since zero is their reset value
  wire high_ok = in_range(reg_wdata_i, '0, pecg_pkg::PART_MAX);
  wire low_ok = in_range(reg_wdata_i, pecg_pkg::PART_MIN, pecg_pkg::PART_MAX);

  // candidate ratio for the next restart
  wire wide_sel = control_q[pecg_pkg::CTL_WIDE_BIT];
  wire [RATIO_W-1:0] wide_num = pecg_pkg::compose(num_high_q, num_low_q);
  wire [RATIO_W-1:0] wide_den = pecg_pkg::compose(den_high_q, den_low_q);
  wire [RATIO_W-1:0] new_num = wide_sel ? wide_num : RATIO_W'(num_short_q);
  wire [RATIO_W-1:0] new_den = wide_sel ? wide_den : RATIO_W'(den_short_q);
  wire new_ok = new_num != '0 && new_den != '0;

  // clear decode
  wire ext_clear = ~error_clear_in_n_i;
  wire [MW-1:0] clr_mode = control_q[pecg_pkg::CTL_MODE_LSB +: MW];
  wire servo_off = ~servo_on_i;
  wire auto_soff = clr_mode == pecg_pkg::MODE_SOFF && servo_off;
  wire auto_ot = clr_mode == pecg_pkg::MODE_SOFF_OT && (servo_off || overtravel_i)
                 && !zero_clamp_i;
  // any other mode, including the unused code, keeps pending pulses
  wire auto_clear = auto_soff || auto_ot;
  wire clear_all = ext_clear || auto_clear;
  wire gear_flush = clear_all || restart;
  wire gear_busy;

  pecg_gear #(
    .NUM_W(RATIO_W)
  ) u_gear (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .flush_i(gear_flush),
    .num_i(act_num_q),
    .den_i(act_den_q),
    .step_i(step_pulse_input_i),
    .step_dir_i(step_dir_i),
    .cnt_o(scaled_count_o),
    .cnt_dir_o(scaled_dir_o),
    .busy_o(gear_busy)
  );

  pecg_errcnt #(
    .W(ERR_W)
  ) u_err (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .clear_i(clear_all),
    .ref_i(scaled_count_o),
    .ref_dir_i(scaled_dir_o),
    .fb_i(feedback_pulse_i),
    .fb_dir_i(feedback_dir_i),
    .err_o(position_error_o)
  );

  // the loop computes nothing while the external clear is held
  assign loop_enable_o = servo_on_i && !ext_clear;
  assign error_clearing_o = clear_all;

  // read path
  logic [DW-1:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[pecg_pkg::ST_LOOP_BIT] = loop_enable_o;
    status_word[pecg_pkg::ST_CLEAR_BIT] = clear_all;
    status_word[pecg_pkg::ST_WIDE_BIT] = act_wide_q;
    status_word[pecg_pkg::ST_BUSY_BIT] = gear_busy;
    status_word[pecg_pkg::ST_CFGERR_BIT] = cfg_err_q;
  end
  wire [ERR_W-1:0] err_word = position_error_o;
  logic [DW-1:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      pecg_pkg::A_NUM_SHORT: rd_mux = num_short_q;
      pecg_pkg::A_DEN_SHORT: rd_mux = den_short_q;
      pecg_pkg::A_NUM_HIGH: rd_mux = num_high_q;
      pecg_pkg::A_NUM_LOW: rd_mux = num_low_q;
      pecg_pkg::A_DEN_HIGH: rd_mux = den_high_q;
      pecg_pkg::A_DEN_LOW: rd_mux = den_low_q;
      pecg_pkg::A_CONTROL: rd_mux = control_q;
      pecg_pkg::A_STATUS: rd_mux = status_word;
      pecg_pkg::A_ERR_LOW: rd_mux = err_word[DW-1:0];
      pecg_pkg::A_ERR_HIGH: rd_mux = err_word[ERR_W-1 -: DW];
      default: rd_mux = '0;
    endcase
  end
  assign reg_rdata_o = rdata_q;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_read_i ? rd_mux : '0;
    end
  end

  // software-written shadows
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      num_short_q <= pecg_pkg::RST_SHORT;
      den_short_q <= pecg_pkg::RST_SHORT;
      num_high_q <= pecg_pkg::RST_HIGH;
      num_low_q <= pecg_pkg::RST_LOW;
      den_high_q <= pecg_pkg::RST_HIGH;
      den_low_q <= pecg_pkg::RST_LOW;
      control_q <= pecg_pkg::RST_CONTROL;
    end else begin
      if (wr_num_short && short_ok) begin
        num_short_q <= reg_wdata_i;
      end
      if (wr_den_short && short_ok) begin
        den_short_q <= reg_wdata_i;
      end
      if (wr_num_high && high_ok) begin
        num_high_q <= reg_wdata_i;
      end
      if (wr_num_low && low_ok) begin
        num_low_q <= reg_wdata_i;
      end
      if (wr_den_high && high_ok) begin
        den_high_q <= reg_wdata_i;
      end
      if (wr_den_low && low_ok) begin
        den_low_q <= reg_wdata_i;
      end
      if (wr_control) begin
        control_q <= reg_wdata_i;
      end
    end
  end

  // ratio in force changes only at a restart, so a half-written pair never runs
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      act_num_q <= pecg_pkg::RST_RATIO;
      act_den_q <= pecg_pkg::RST_RATIO;
      act_wide_q <= 1'b0;
      cfg_err_q <= 1'b0;
    end else if (restart) begin
      cfg_err_q <= !new_ok;
      if (new_ok) begin
        act_num_q <= new_num;
        act_den_q <= new_den;
        act_wide_q <= wide_sel;
      end
    end
  end
endmodule

// [dv/pecg_top_checker.sv]
/*
  pecg_top_checker: port-level assertions for pecg_top.
  Assumes one clock domain with an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module pecg_top_checker #(
  parameter int RATIO_W = 32,
  parameter int ERR_W = 32
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // watched ports
  input wire logic reg_read_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic error_clear_in_n_i,
  input wire logic servo_on_i,
  input wire logic feedback_pulse_i,
  input wire logic feedback_dir_i,
  input wire logic [ERR_W-1:0] position_error_o,
  input wire logic loop_enable_o,
  input wire logic error_clearing_o,
  input wire logic scaled_count_o,
  input wire logic scaled_dir_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_clr2;
    !error_clear_in_n_i [*2];
  endsequence
  sequence s_quiet;
    !scaled_count_o && !feedback_pulse_i && !error_clearing_o;
  endsequence
  property p_loop;
    loop_enable_o == (servo_on_i && error_clear_in_n_i);
  endproperty
  a_loop: assert property (p_loop) else $error("loop enable wrong");
  property p_clr_flag;
    !error_clear_in_n_i |-> error_clearing_o;
  endproperty
  a_clr_flag: assert property (p_clr_flag) else $error("clear flag low");
  property p_clr_zero;
    s_clr2 |=> position_error_o == '0 && !scaled_count_o;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("error not zeroed");
  property p_no_cnt;
    error_clearing_o |=> !scaled_count_o;
  endproperty
  a_no_cnt: assert property (p_no_cnt) else $error("count during clear");
  property p_rdata_idle;
    !reg_read_i |=> reg_rdata_o == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  // an all-ones step is minus one in the signed counter
  property p_cnt_err;
    scaled_count_o && !feedback_pulse_i && !error_clearing_o |=>
      position_error_o - $past(position_error_o) == ($past(scaled_dir_o) ? 1 : {ERR_W{1'b1}});
  endproperty
  a_cnt_err: assert property (p_cnt_err) else $error("count not added");
  property p_fb_err;
    feedback_pulse_i && !scaled_count_o && !error_clearing_o |=>
      position_error_o - $past(position_error_o) == ($past(feedback_dir_i) ? {ERR_W{1'b1}} : 1);
  endproperty
  a_fb_err: assert property (p_fb_err) else $error("feedback not applied");
  property p_hold;
    s_quiet |=> $stable(position_error_o);
  endproperty
  a_hold: assert property (p_hold) else $error("error moved idle");
endmodule

bind pecg_top pecg_top_checker #(.RATIO_W(RATIO_W), .ERR_W(ERR_W)) i_pecg_top_checker (
  .core_clk_i, .reset_i, .reg_read_i, .reg_rdata_o, .error_clear_in_n_i, .servo_on_i,
  .feedback_pulse_i, .feedback_dir_i, .position_error_o, .loop_enable_o,
  .error_clearing_o, .scaled_count_o, .scaled_dir_o
);

// [dv/pecg_host.sv]
/*
  pecg_host: host controller model sending sign plus pulse bursts.
  Assumes a burst is started only while busy_o is low.
*/
`timescale 1ns/1ps
module pecg_host (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // burst request
  input wire logic start_i,
  input wire logic fwd_i,
  input wire logic [7:0] steps_i,
  input wire logic [3:0] gap_i,
  // reference out
  output logic step_o,
  output logic dir_o,
  output logic busy_o
);
  logic [7:0] left_q;
  logic [3:0] wait_q;
  logic dir_q;
  assign busy_o = (left_q != 8'h00);
  // direction only counts beside a step, so it flips in between
  assign dir_o = step_o ? dir_q : !dir_q;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      left_q <= 8'h00;
      wait_q <= 4'h0;
      dir_q <= 1'b0;
      step_o <= 1'b0;
    end else if (start_i) begin
      left_q <= steps_i;
      wait_q <= 4'h0;
      dir_q <= fwd_i;
      step_o <= 1'b0;
    end else if (busy_o && wait_q == 4'h0) begin
      left_q <= left_q - 8'h01;
      wait_q <= gap_i;
      step_o <= 1'b1;
    end else begin
      wait_q <= (wait_q == 4'h0) ? 4'h0 : wait_q - 4'h1;
      step_o <= 1'b0;
    end
  end
endmodule

// [dv/position_error_clear_and_gear_bench.sv]
/*
  bench for pecg_top: register tasks, host bursts, feedback and clear cases.
  Assumes the checker is bound to pecg_top and the host model is present.
*/
`timescale 1ns/1ps
module position_error_clear_and_gear_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic we = 1'b0, re = 1'b0, clr_n = 1'b1, son = 1'b0, ot = 1'b0, zc = 1'b0;
  logic fb = 1'b0, fbd = 1'b0, go = 1'b0, gfwd = 1'b0;
  logic [7:0] gn = 8'h00;
  logic [3:0] gg = 4'h0;
  logic [15:0] rdata;
  logic [31:0] perr;
  logic step, sdir, busy, loop_en, clring;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  always #2.5 clk = !clk;
  pecg_top i_pecg_top (
    .core_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_write_i(we), .reg_read_i(re), .reg_rdata_o(rdata), .step_pulse_input_i(step),
    .step_dir_i(sdir), .error_clear_in_n_i(clr_n), .servo_on_i(son), .overtravel_i(ot),
    .zero_clamp_i(zc), .feedback_pulse_i(fb), .feedback_dir_i(fbd), .position_error_o(perr),
    .loop_enable_o(loop_en), .error_clearing_o(clring), .scaled_count_o(), .scaled_dir_o());
  pecg_host i_pecg_host (
    .core_clk_i(clk), .reset_i(rst), .start_i(go), .fwd_i(gfwd), .steps_i(gn),
    .gap_i(gg), .step_o(step), .dir_o(sdir), .busy_o(busy));
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(32'(rdata), e);
  endtask
  task automatic run(input logic f, input logic [7:0] n, input logic [3:0] g);
    @(posedge clk);
    go <= 1'b1;
    gfwd <= f;
    gn <= n;
    gg <= g;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  task automatic fbk(input int n);
    repeat (n) begin
      @(posedge clk);
      fb <= 1'b1;
      @(posedge clk);
      fb <= 1'b0;
    end
  endtask
  task automatic clr_case(input logic [1:0] m, input logic s, input logic o,
                          input logic z, input logic c);
    wr(pecg_pkg::A_CONTROL, {13'h0000, m, 1'b0});
    @(posedge clk);
    clr_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(perr, 32'h0);
    chk(32'(loop_en), 32'h0);
    @(posedge clk);
    clr_n <= 1'b1;
    fbk(3);
    @(posedge clk);
    son <= s;
    ot <= o;
    zc <= z;
    repeat (3) @(posedge clk);
    #1;
    chk(32'(clring), 32'(c));
    chk(perr, c ? 32'h0 : 32'h3);
    @(posedge clk);
    son <= 1'b1;
    ot <= 1'b0;
    zc <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    son <= 1'b1;
    for (int i = 0; i < 6; i++) rd(4'(i), (i == 2 || i == 4) ? 32'h0 : 32'h1);
    rd(pecg_pkg::A_CONTROL, 32'h0);
    rd(4'hF, 32'h0);
    rd(pecg_pkg::A_STATUS, 32'h1);
    run(1'b1, 8'h05, 4'h1);
    chk(perr, 32'h5);
    wr(pecg_pkg::A_NUM_SHORT, 16'h0003);
    wr(pecg_pkg::A_DEN_SHORT, 16'h0002);
    wr(pecg_pkg::A_NUM_SHORT, 16'h0000);
    rd(pecg_pkg::A_NUM_SHORT, 32'h3);
    run(1'b1, 8'h04, 4'h3);
    chk(perr, 32'h9);
    wr(pecg_pkg::A_RESTART, 16'h0000);
    run(1'b1, 8'h04, 4'h3);
    chk(perr, 32'hF);
    run(1'b0, 8'h02, 4'h3);
    chk(perr, 32'hC);
    // 19999 over 9999 stays inside the legal ratio band
    wr(pecg_pkg::A_NUM_HIGH, 16'h0001);
    wr(pecg_pkg::A_NUM_LOW, 16'h270F);
    wr(pecg_pkg::A_DEN_LOW, 16'h270F);
    wr(pecg_pkg::A_DEN_LOW, 16'h2710);
    rd(pecg_pkg::A_DEN_LOW, 32'h270F);
    wr(pecg_pkg::A_CONTROL, 16'h0001);
    wr(pecg_pkg::A_RESTART, 16'h0000);
    rd(pecg_pkg::A_STATUS, 32'h5);
    run(1'b1, 8'h03, 4'h3);
    rd(pecg_pkg::A_ERR_LOW, 32'h12);
    rd(pecg_pkg::A_ERR_HIGH, 32'h0);
    clr_case(2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
    clr_case(2'h0, 1'b1, 1'b1, 1'b0, 1'b0);
    clr_case(2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    clr_case(2'h2, 1'b1, 1'b1, 1'b0, 1'b1);
    clr_case(2'h2, 1'b1, 1'b1, 1'b1, 1'b0);
    clr_case(2'h2, 1'b0, 1'b0, 1'b0, 1'b1);
    clr_case(2'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule
